// >>> design/dcs_regs.sv
/*
  Debug control/status, debug return pc, scratch pair, 64-bit cycle and
  retired counters, hardwired event slots, security control, three seed
  registers and the two identification registers.
  Assumes the pipeline presents one register access per cycle (csr_we/csr_re
  with address and data) and reads csr_rdata the following cycle; debug
  entry, privilege, retire and nmi events come from logic on the same clock.
*/
// Contract
// - debug control top nibble reads constant 4, writes ignored.
// - machine-mode ebreak enters debug when machine break bit set.
// - user-mode ebreak enters debug when user break bit set.
// - step interrupt bit allows interrupts while stepping; clear masks them.
// - cause field is read only, shows latest debug entry reason.
// - read-only bit shows pending non-maskable interrupt.
// - writable step bit makes core step once then re-enter debug.
// - prior privilege holds 0 or 3 only; other writes legalized.
// - counter/timer halts, other breaks, virt and mprv read zero.
// - return pc loads next pc on debug entry, also software writable.
// - two scratch registers, read/write, cleared by reset.
// - 64-bit cycle counter, both words read/write, reset zero.
// - 64-bit retired counter, both words read/write, reset zero.
// - event slots 3 to 31 low and high read zero, drop writes.
// - filler interval field picks random interval between dummy instructions.
// - noise bit drives random data into unused functional units.
// - hint bit replaces set-less-than hints with harmless random ones.
// - filler bit inserts dummy instructions at chosen interval.
// - constant time bit makes execution time data independent.
// - security control register always reads zero.
// - three seed registers load their generator seed, read zero.
// - maker code holds continuation count and final id byte.
// - architecture code is fixed read-only value, writes ignored.
// - counters inhibited after reset; bit 0 cycle, bit 2 retired.
module dcs_regs #(
  parameter logic [24:0] MAKER_BANK_COUNT = 25'h0000001, // arbitrary value
  parameter logic [6:0] MAKER_FINAL_BYTE = 7'h01, // arbitrary value
  parameter logic [31:0] ARCH_CODE = 32'h0000_0001 // arbitrary value
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic csr_we,
  input wire logic csr_re,
  input wire logic [11:0] csr_addr,
  input wire logic [31:0] csr_wdata,
  input wire logic debug_entry,
  input wire logic [2:0] debug_entry_cause,
  input wire logic [31:0] debug_entry_next_pc,
  input wire logic [1:0] debug_entry_priv,
  input wire logic ebreak_exec,
  input wire logic [1:0] cur_priv,
  input wire logic nmi_pending_in,
  input wire logic instr_retired,
  output logic [31:0] csr_rdata,
  output logic csr_rvalid,
  output logic ebreak_to_debug,
  output logic step_en,
  output logic step_irq_mask,
  output logic [31:0] debug_return_pc,
  output logic [3:0] filler_insert_interval,
  output logic idle_unit_noise_en,
  output logic hint_randomize_en,
  output logic filler_insert_en,
  output logic constant_time_en,
  output logic [31:0] random_gen_zero_seed,
  output logic [31:0] random_gen_one_seed,
  output logic [31:0] random_gen_two_seed,
  output logic [2:0] seed_load
);
  logic brk_to_debug_machine_q;
  logic brk_to_debug_user_q;
  logic step_irq_allow_q;
  logic step_q;
  logic [2:0] cause_q;
  logic nonmaskable_pending_q;
  logic [1:0] prior_privilege_q;
  logic [31:0] dpc_q;
  logic [31:0] scratch_q [2];
  logic [63:0] cycle_q;
  logic [63:0] retired_q;
  logic [31:0] inhibit_q;
  logic [3:0] freq_q;
  logic [3:0] feat_q;
  logic [31:0] seed_q [3];
  logic [2:0] seed_load_q;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic [31:0] dbg_word;

  // write strobe for one address
  function automatic logic wr_hit(input logic we, input logic [11:0] a, input logic [11:0] t);
    wr_hit = we && (a == t);
  endfunction : wr_hit

  // any value other than user is taken as machine
  function automatic logic [1:0] legal_priv(input logic [1:0] p);
    legal_priv = (p == dcs_pkg::PRV_USER) ? dcs_pkg::PRV_USER : dcs_pkg::PRV_MACHINE;
  endfunction : legal_priv

  // assembled debug control word; unlisted fields stay zero
  always_comb begin
    dbg_word = dcs_pkg::ZERO_WORD;
    dbg_word[dcs_pkg::DBG_VER_LSB +: 4] = dcs_pkg::DBG_VER_VALUE;
    dbg_word[dcs_pkg::DBG_BRK_M_BIT] = brk_to_debug_machine_q;
    dbg_word[dcs_pkg::DBG_BRK_U_BIT] = brk_to_debug_user_q;
    dbg_word[dcs_pkg::DBG_STEP_IRQ_ALLOW_BIT] = step_irq_allow_q;
    dbg_word[dcs_pkg::DBG_CAUSE_LSB +: 3] = cause_q;
    dbg_word[dcs_pkg::DBG_NONMASKABLE_PENDING_BIT] = nonmaskable_pending_q;
    dbg_word[dcs_pkg::DBG_STEP_BIT] = step_q;
    dbg_word[dcs_pkg::DBG_PRV_LSB +: 2] = prior_privilege_q;
  end

  // debug control: hardware entry beats a software write of the privilege field in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      brk_to_debug_machine_q <= 1'b0;
      brk_to_debug_user_q <= 1'b0;
      step_irq_allow_q <= 1'b0;
      step_q <= 1'b0;
      cause_q <= dcs_pkg::DCS_CAUSE_NONE;
      prior_privilege_q <= dcs_pkg::PRV_RESET;
    end else begin
      if (wr_hit(csr_we, csr_addr, dcs_pkg::ADDR_DEBUG_CTRL_STATUS)) begin
        brk_to_debug_machine_q <= csr_wdata[dcs_pkg::DBG_BRK_M_BIT];
        brk_to_debug_user_q <= csr_wdata[dcs_pkg::DBG_BRK_U_BIT];
        step_irq_allow_q <= csr_wdata[dcs_pkg::DBG_STEP_IRQ_ALLOW_BIT];
        step_q <= csr_wdata[dcs_pkg::DBG_STEP_BIT];
        prior_privilege_q <= legal_priv(csr_wdata[dcs_pkg::DBG_PRV_LSB +: 2]);
      end
      if (debug_entry) begin
        cause_q <= debug_entry_cause;
        prior_privilege_q <= legal_priv(debug_entry_priv);
      end
    end
  end

  // nmi status sampled from the pipeline, read-only to software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nonmaskable_pending_q <= 1'b0;
    end else begin
      nonmaskable_pending_q <= nmi_pending_in;
    end
  end

  // return pc: entry capture wins over a simultaneous write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dpc_q <= dcs_pkg::ZERO_WORD;
    end else if (debug_entry) begin
      dpc_q <= debug_entry_next_pc;
    end else if (wr_hit(csr_we, csr_addr, dcs_pkg::ADDR_DEBUG_RETURN_PC)) begin
      dpc_q <= csr_wdata;
    end
  end

  // scratch pair
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scratch_q[0] <= dcs_pkg::ZERO_WORD;
      scratch_q[1] <= dcs_pkg::ZERO_WORD;
    end else begin
      if (wr_hit(csr_we, csr_addr, dcs_pkg::ADDR_DEBUG_SCRATCH_ZERO)) begin
        scratch_q[0] <= csr_wdata;
      end
      if (wr_hit(csr_we, csr_addr, dcs_pkg::ADDR_DEBUG_SCRATCH_ONE)) begin
        scratch_q[1] <= csr_wdata;
      end
    end
  end

  // counter inhibit: only the two implemented bits are kept
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      inhibit_q <= dcs_pkg::INHIBIT_RESET;
    end else if (wr_hit(csr_we, csr_addr, dcs_pkg::ADDR_COUNTER_INHIBIT)) begin
      inhibit_q <= dcs_pkg::ZERO_WORD;
      inhibit_q[dcs_pkg::INH_CYCLE_BIT] <= csr_wdata[dcs_pkg::INH_CYCLE_BIT];
      inhibit_q[dcs_pkg::INH_RETIRED_BIT] <= csr_wdata[dcs_pkg::INH_RETIRED_BIT];
    end
  end

  // cycle counter; a word write overrides that cycle's increment
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cycle_q <= 64'h0000_0000_0000_0000;
    end else if (wr_hit(csr_we, csr_addr, dcs_pkg::ADDR_CYCLE_COUNT_LOW)) begin
      cycle_q[31:0] <= csr_wdata;
    end else if (wr_hit(csr_we, csr_addr, dcs_pkg::ADDR_CYCLE_COUNT_HIGH)) begin
      cycle_q[63:32] <= csr_wdata;
    end else if (!inhibit_q[dcs_pkg::INH_CYCLE_BIT]) begin
      cycle_q <= cycle_q + 64'h0000_0000_0000_0001;
    end
  end

  // retired counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      retired_q <= 64'h0000_0000_0000_0000;
    end else if (wr_hit(csr_we, csr_addr, dcs_pkg::ADDR_RETIRED_COUNT_LOW)) begin
      retired_q[31:0] <= csr_wdata;
    end else if (wr_hit(csr_we, csr_addr, dcs_pkg::ADDR_RETIRED_COUNT_HIGH)) begin
      retired_q[63:32] <= csr_wdata;
    end else if (!inhibit_q[dcs_pkg::INH_RETIRED_BIT] && instr_retired) begin
      retired_q <= retired_q + 64'h0000_0000_0000_0001;
    end
  end

  // security features: stored but never read back
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      freq_q <= dcs_pkg::FREQ_RESET;
      feat_q <= 4'h0;
    end else if (wr_hit(csr_we, csr_addr, dcs_pkg::ADDR_SECURITY_FEATURE_CTRL)) begin
      freq_q <= csr_wdata[dcs_pkg::SEC_FREQ_LSB +: 4];
      feat_q <= csr_wdata[3:0];
    end
  end

  // seeds: value held plus a one-cycle load pulse per generator
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seed_q[0] <= dcs_pkg::ZERO_WORD;
      seed_q[1] <= dcs_pkg::ZERO_WORD;
      seed_q[2] <= dcs_pkg::ZERO_WORD;
      seed_load_q <= 3'h0;
    end else begin
      seed_load_q[0] <= wr_hit(csr_we, csr_addr, dcs_pkg::ADDR_RANDOM_SEED_ZERO);
      seed_load_q[1] <= wr_hit(csr_we, csr_addr, dcs_pkg::ADDR_RANDOM_SEED_ONE);
      seed_load_q[2] <= wr_hit(csr_we, csr_addr, dcs_pkg::ADDR_RANDOM_SEED_TWO);
      if (wr_hit(csr_we, csr_addr, dcs_pkg::ADDR_RANDOM_SEED_ZERO)) begin
        seed_q[0] <= csr_wdata;
      end
      if (wr_hit(csr_we, csr_addr, dcs_pkg::ADDR_RANDOM_SEED_ONE)) begin
        seed_q[1] <= csr_wdata;
      end
      if (wr_hit(csr_we, csr_addr, dcs_pkg::ADDR_RANDOM_SEED_TWO)) begin
        seed_q[2] <= csr_wdata;
      end
    end
  end

  // read mux, registered; event slots, seeds, security word read zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= dcs_pkg::ZERO_WORD;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= csr_re;
      rdata_q <= dcs_pkg::ZERO_WORD;
      if (csr_re) begin
        case (csr_addr)
          dcs_pkg::ADDR_DEBUG_CTRL_STATUS: rdata_q <= dbg_word;
          dcs_pkg::ADDR_DEBUG_RETURN_PC: rdata_q <= dpc_q;
          dcs_pkg::ADDR_DEBUG_SCRATCH_ZERO: rdata_q <= scratch_q[0];
          dcs_pkg::ADDR_DEBUG_SCRATCH_ONE: rdata_q <= scratch_q[1];
          dcs_pkg::ADDR_COUNTER_INHIBIT: rdata_q <= inhibit_q;
          dcs_pkg::ADDR_CYCLE_COUNT_LOW: rdata_q <= cycle_q[31:0];
          dcs_pkg::ADDR_CYCLE_COUNT_HIGH: rdata_q <= cycle_q[63:32];
          dcs_pkg::ADDR_RETIRED_COUNT_LOW: rdata_q <= retired_q[31:0];
          dcs_pkg::ADDR_RETIRED_COUNT_HIGH: rdata_q <= retired_q[63:32];
          dcs_pkg::ADDR_MAKER_CODE: rdata_q <= {MAKER_BANK_COUNT, MAKER_FINAL_BYTE};
          dcs_pkg::ADDR_ARCHITECTURE_CODE: rdata_q <= ARCH_CODE;
          default: rdata_q <= dcs_pkg::ZERO_WORD;
        endcase
      end
    end
  end

  // control outputs to the pipeline, one cycle behind the state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ebreak_to_debug <= 1'b0;
      step_en <= 1'b0;
      step_irq_mask <= 1'b1;
      debug_return_pc <= dcs_pkg::ZERO_WORD;
    end else begin
      ebreak_to_debug <= ebreak_exec &&
        ((cur_priv == dcs_pkg::PRV_MACHINE && brk_to_debug_machine_q) ||
         (cur_priv == dcs_pkg::PRV_USER && brk_to_debug_user_q));
      step_en <= step_q;
      step_irq_mask <= step_q && !step_irq_allow_q;
      debug_return_pc <= dpc_q;
    end
  end

  // security enables to the pipeline and generators
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      filler_insert_interval <= dcs_pkg::FREQ_RESET;
      idle_unit_noise_en <= 1'b0;
      hint_randomize_en <= 1'b0;
      filler_insert_en <= 1'b0;
      constant_time_en <= 1'b0;
    end else begin
      filler_insert_interval <= freq_q;
      idle_unit_noise_en <= feat_q[dcs_pkg::SEC_NOISE_BIT];
      hint_randomize_en <= feat_q[dcs_pkg::SEC_HINT_BIT];
      filler_insert_en <= feat_q[dcs_pkg::SEC_FILLER_BIT];
      constant_time_en <= feat_q[dcs_pkg::SEC_CONST_TIME_BIT];
    end
  end

  assign csr_rdata = rdata_q;
  assign csr_rvalid = rvalid_q;
  assign random_gen_zero_seed = seed_q[0];
  assign random_gen_one_seed = seed_q[1];
  assign random_gen_two_seed = seed_q[2];
  assign seed_load = seed_load_q;
endmodule : dcs_regs

// >>> pkg/dcs_pkg.sv
/*
  Package for the debug, counter and security register bank: addresses,
  field positions, reset values and the debug-cause codes.
  Assumes a 12-bit register address from the pipeline's register access port.
*/
package dcs_pkg;
  localparam logic [11:0] ADDR_DEBUG_CTRL_STATUS = 12'h7b0;
  localparam logic [11:0] ADDR_DEBUG_RETURN_PC = 12'h7b1;
  localparam logic [11:0] ADDR_DEBUG_SCRATCH_ZERO = 12'h7b2;
  localparam logic [11:0] ADDR_DEBUG_SCRATCH_ONE = 12'h7b3;
  localparam logic [11:0] ADDR_COUNTER_INHIBIT = 12'h320;
  localparam logic [11:0] ADDR_CYCLE_COUNT_LOW = 12'hb00;
  localparam logic [11:0] ADDR_RETIRED_COUNT_LOW = 12'hb02;
  localparam logic [11:0] ADDR_EVENT_LOW_FIRST = 12'hb03;
  localparam logic [11:0] ADDR_EVENT_LOW_LAST = 12'hb1f;
  localparam logic [11:0] ADDR_CYCLE_COUNT_HIGH = 12'hb80;
  localparam logic [11:0] ADDR_RETIRED_COUNT_HIGH = 12'hb82;
  localparam logic [11:0] ADDR_EVENT_HIGH_FIRST = 12'hb83;
  localparam logic [11:0] ADDR_EVENT_HIGH_LAST = 12'hb9f;
  localparam logic [11:0] ADDR_SECURITY_FEATURE_CTRL = 12'hbf0;
  localparam logic [11:0] ADDR_RANDOM_SEED_ZERO = 12'hbf9;
  localparam logic [11:0] ADDR_RANDOM_SEED_ONE = 12'hbfa;
  localparam logic [11:0] ADDR_RANDOM_SEED_TWO = 12'hbfc;
  localparam logic [11:0] ADDR_MAKER_CODE = 12'hf11;
  localparam logic [11:0] ADDR_ARCHITECTURE_CODE = 12'hf12;

  // debug control/status field positions
  localparam int DBG_VER_LSB = 28;
  localparam logic [3:0] DBG_VER_VALUE = 4'h4;
  localparam int DBG_BRK_M_BIT = 15;
  localparam int DBG_BRK_U_BIT = 12;
  localparam int DBG_STEP_IRQ_ALLOW_BIT = 11;
  localparam int DBG_CAUSE_LSB = 6;
  localparam int DBG_NONMASKABLE_PENDING_BIT = 3;
  localparam int DBG_STEP_BIT = 2;
  localparam int DBG_PRV_LSB = 0;
  localparam logic [1:0] PRV_USER = 2'h0;
  localparam logic [1:0] PRV_MACHINE = 2'h3;
  localparam logic [1:0] PRV_RESET = 2'h3;

  // counter-inhibit bits; all inhibited at reset
  localparam int INH_CYCLE_BIT = 0;
  localparam int INH_RETIRED_BIT = 2;
  localparam logic [31:0] INHIBIT_RESET = 32'h0000_0005;

  // security control field positions
  localparam int SEC_FREQ_LSB = 16;
  localparam int SEC_NOISE_BIT = 3;
  localparam int SEC_HINT_BIT = 2;
  localparam int SEC_FILLER_BIT = 1;
  localparam int SEC_CONST_TIME_BIT = 0;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [3:0] FREQ_RESET = 4'h0;

  // debug entry causes
  typedef enum logic [2:0] {
    DCS_CAUSE_NONE = 3'b000,
    DCS_CAUSE_EBREAK = 3'b001,
    DCS_CAUSE_TRIGGER = 3'b010,
    DCS_CAUSE_HALTREQ = 3'b011,
    DCS_CAUSE_STEP = 3'b100
  } dcs_cause_t;
endpackage : dcs_pkg

// >>> testbench/dcs_pipe_model.sv
/*
  Pipeline stand-in: random retire pulses while run is high, nmi level.
  Assumes the bench changes run and nmi_set at falling edges.
*/
module dcs_pipe_model (
  input wire logic clk,
  input wire logic run,
  input wire logic nmi_set,
  output logic instr_retired,
  output logic nmi_pending_in,
  output logic [31:0] ret_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pulse;
  // quiet start
  initial begin
    instr_retired = 1'b0;
    nmi_pending_in = 1'b0;
    ret_cnt = 32'h0;
  end
  // falling-edge drive so the bank samples settled levels
  always @(negedge clk) begin
    pulse = run & 1'($urandom_range(0, 1));
    instr_retired <= pulse;
    nmi_pending_in <= nmi_set;
    ret_cnt <= ret_cnt + 32'(pulse);
  end
endmodule : dcs_pipe_model

// >>> testbench/dcs_regs_monitor.sv
/*
  Port checker for the debug, counter and security register bank.
  Assumes the one-cycle read answer and the write timing of the bank.
*/
module dcs_regs_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic csr_we,
  input wire logic csr_re,
  input wire logic [11:0] csr_addr,
  input wire logic [31:0] csr_wdata,
  input wire logic ebreak_exec,
  input wire logic debug_entry,
  input wire logic [31:0] csr_rdata,
  input wire logic csr_rvalid,
  input wire logic ebreak_to_debug,
  input wire logic [3:0] filler_insert_interval,
  input wire logic idle_unit_noise_en,
  input wire logic hint_randomize_en,
  input wire logic filler_insert_en,
  input wire logic constant_time_en,
  input wire logic [31:0] random_gen_zero_seed,
  input wire logic [2:0] seed_load
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] wdata_one_q;
  logic [31:0] wdata_two_q;
  logic sec_wr;
  logic ev_rd;
  // write data two edges back, the security copies lag that far
  always_ff @(posedge clk) begin
    wdata_one_q <= csr_wdata;
    wdata_two_q <= wdata_one_q;
  end
  // decoded strobes
  assign sec_wr = csr_we && csr_addr == 12'hbf0;
  assign ev_rd = csr_re && (csr_addr inside {[12'hb03:12'hb1f], [12'hb83:12'hb9f]});
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_read_answered: assert property (csr_re |=> csr_rvalid)
    else $error("read strobe not answered");
  a_no_stray_valid: assert property (!csr_re |=> !csr_rvalid)
    else $error("read valid without a read");
  a_version_nibble: assert property (csr_re && csr_addr == 12'h7b0 |=>
    csr_rdata[31:28] == 4'h4) else $error("debug version field wrong");
  a_event_zero: assert property (ev_rd |=> csr_rdata == 32'h0)
    else $error("event slot read not zero");
  a_sec_read_zero: assert property (csr_re && csr_addr == 12'hbf0 |=>
    csr_rdata == 32'h0) else $error("security word read not zero");
  a_seed_loads: assert property (csr_we && csr_addr == 12'hbf9 |=>
    seed_load[0] && random_gen_zero_seed == $past(csr_wdata)) else $error("seed not loaded");
  a_sec_copy: assert property (sec_wr |=> ##1
    {filler_insert_interval, idle_unit_noise_en, hint_randomize_en, filler_insert_en,
    constant_time_en} == {wdata_two_q[19:16], wdata_two_q[3:0]})
    else $error("security controls not copied");
  a_ebreak_cause: assert property (ebreak_to_debug |-> $past(ebreak_exec))
    else $error("debug break without ebreak");
  c_break: cover property (ebreak_to_debug);
  c_entry: cover property (debug_entry);
  c_seed: cover property (seed_load[0]);
endmodule : dcs_regs_monitor

bind dcs_regs dcs_regs_monitor i_dcs_regs_monitor (
  .clk(clk), .sys_rst(sys_rst), .csr_we(csr_we), .csr_re(csr_re), .csr_addr(csr_addr),
  .csr_wdata(csr_wdata), .ebreak_exec(ebreak_exec), .debug_entry(debug_entry),
  .csr_rdata(csr_rdata), .csr_rvalid(csr_rvalid), .ebreak_to_debug(ebreak_to_debug),
  .filler_insert_interval(filler_insert_interval), .idle_unit_noise_en(idle_unit_noise_en),
  .hint_randomize_en(hint_randomize_en), .filler_insert_en(filler_insert_en),
  .constant_time_en(constant_time_en), .random_gen_zero_seed(random_gen_zero_seed),
  .seed_load(seed_load)
);

// >>> testbench/dcs_regs_tb.sv
/*
  Self-checking bench for the register bank: reset values, field legality,
  debug events, counters, security and seed words, identity words.
  Assumes the bank answers a read one cycle after the strobe.
*/
module dcs_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
  localparam logic [24:0] BANKS = 25'h0000003; // arbitrary value
  localparam logic [6:0] LAST_BYTE = 7'h05; // arbitrary value
  localparam logic [31:0] ARCH = 32'h0000_00a7; // arbitrary value
  logic clk, sys_rst, csr_we, csr_re, debug_entry, ebreak_exec, run, nmi_set;
  logic nmi_pending_in, instr_retired, csr_rvalid, ebreak_to_debug, step_en, step_irq_mask;
  logic idle_unit_noise_en, hint_randomize_en, filler_insert_en, constant_time_en;
  logic [11:0] csr_addr, a;
  logic [31:0] csr_wdata, debug_entry_next_pc, csr_rdata, debug_return_pc, ret_cnt, v, w;
  logic [31:0] seed0, seed1, seed2;
  logic [3:0] filler_insert_interval;
  logic [2:0] debug_entry_cause, seed_load;
  logic [1:0] debug_entry_priv, cur_priv;
  logic [11:0] zr [7] = '{12'h7b1, 12'h7b2, 12'h7b3, 12'hb00, 12'hb80, 12'hb02, 12'hb82};
  logic [11:0] sa [3] = '{12'hbf9, 12'hbfa, 12'hbfc};
  int error_cnt = 0;
  int checks_done = 0;
  dcs_regs #(.MAKER_BANK_COUNT(BANKS), .MAKER_FINAL_BYTE(LAST_BYTE), .ARCH_CODE(ARCH)) i_dcs_regs (
    .clk(clk), .sys_rst(sys_rst), .csr_we(csr_we), .csr_re(csr_re), .csr_addr(csr_addr),
    .csr_wdata(csr_wdata), .debug_entry(debug_entry), .debug_entry_cause(debug_entry_cause),
    .debug_entry_next_pc(debug_entry_next_pc), .debug_entry_priv(debug_entry_priv),
    .ebreak_exec(ebreak_exec), .cur_priv(cur_priv), .nmi_pending_in(nmi_pending_in),
    .instr_retired(instr_retired), .csr_rdata(csr_rdata), .csr_rvalid(csr_rvalid),
    .ebreak_to_debug(ebreak_to_debug), .step_en(step_en), .step_irq_mask(step_irq_mask),
    .debug_return_pc(debug_return_pc), .filler_insert_interval(filler_insert_interval),
    .idle_unit_noise_en(idle_unit_noise_en), .hint_randomize_en(hint_randomize_en),
    .filler_insert_en(filler_insert_en), .constant_time_en(constant_time_en),
    .random_gen_zero_seed(seed0), .random_gen_one_seed(seed1), .random_gen_two_seed(seed2),
    .seed_load(seed_load));
  dcs_pipe_model i_dcs_pipe_model (.clk(clk), .run(run), .nmi_set(nmi_set),
    .instr_retired(instr_retired), .nmi_pending_in(nmi_pending_in), .ret_cnt(ret_cnt));
  // 25 MHz core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic finish_test;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  // one write, strobe dropped a full cycle before the next access
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    @(negedge clk);
    csr_we = 1'b1;
    csr_addr = ad;
    csr_wdata = d;
    @(negedge clk);
    csr_we = 1'b0;
  endtask : wr
  // one read, answer taken in the cycle after the strobe
  task automatic rd(input logic [11:0] ad, output logic [31:0] d);
    @(negedge clk);
    csr_re = 1'b1;
    csr_addr = ad;
    @(negedge clk);
    d = csr_rdata;
    `CHK("rvalid", 1'b1, csr_rvalid)
    csr_re = 1'b0;
  endtask : rd
  task automatic rc(input logic [11:0] ad, input logic [31:0] e);
    logic [31:0] d;
    rd(ad, d);
    `CHK($sformatf("reg %h", ad), e, d)
  endtask : rc
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  // main sequence
  initial begin
    void'($urandom(32'h0ad52a2f));
    {sys_rst, csr_we, csr_re, debug_entry, ebreak_exec, run, nmi_set} = 7'h40;
    {csr_addr, csr_wdata, debug_entry_next_pc} = '0;
    {debug_entry_cause, debug_entry_priv, cur_priv} = '0;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    rc(12'h7b0, 32'h4000_0003);
    rc(12'h320, 32'h5);
    foreach (zr[i]) rc(zr[i], 32'h0);
    wr(12'h7b0, 32'hffff_ffff);
    rc(12'h7b0, 32'h4000_9807);
    `CHK("step_en", 1'b1, step_en)
    `CHK("irq_mask", 1'b0, step_irq_mask)
    wr(12'h7b0, 32'h6);
    rc(12'h7b0, 32'h4000_0007);
    `CHK("irq_mask", 1'b1, step_irq_mask)
    // break bit against privilege, every pairing
    for (int i = 0; i < 4; i++) begin
      wr(12'h7b0, i[0] ? 32'h8000 : 32'h1000);
      @(negedge clk);
      ebreak_exec = 1'b1;
      cur_priv = i[1] ? 2'h3 : 2'h0;
      @(negedge clk);
      ebreak_exec = 1'b0;
      `CHK("ebreak", i[0] == i[1], ebreak_to_debug)
    end
    // debug entry for each cause, nmi toggled alongside
    for (int c = 1; c <= 4; c++) begin
      w = $urandom;
      nmi_set <= c[1];
      wr(12'h7b0, 32'h0);
      @(negedge clk);
      {debug_entry, debug_entry_cause, debug_entry_next_pc} = {1'b1, 3'(c), w};
      debug_entry_priv = c[0] ? 2'h3 : 2'h0;
      @(negedge clk);
      debug_entry = 1'b0;
      // nmi and privilege fields built at full width, a 1-bit shift would vanish
      v = (c[1] ? 32'h8 : 32'h0) | (c[0] ? 32'h3 : 32'h0);
      rc(12'h7b0, 32'h4000_0000 | 32'(c << 6) | v);
      rc(12'h7b1, w);
      `CHK("ret_pc", w, debug_return_pc)
    end
    for (int i = 0; i < 3; i++) begin
      w = $urandom;
      wr(zr[i], w);
      rc(zr[i], w);
    end
    w = $urandom;
    wr(12'h320, 32'hffff_ffff);
    rc(12'h320, 32'h5);
    wr(12'hb00, w);
    wr(12'hb80, ~w);
    wr(12'hb82, w);
    rc(12'hb00, w);
    rc(12'hb80, ~w);
    rc(12'hb82, w);
    wr(12'hb02, 32'h0);
    wr(12'h320, 32'h0);
    run <= 1'b1;
    repeat (40) @(negedge clk);
    run <= 1'b0;
    repeat (3) @(negedge clk);
    rc(12'hb02, ret_cnt);
    rd(12'hb00, v);
    rd(12'hb00, w);
    `CHK("cycle_step", v + 32'h2, w)
    wr(12'hb80, 32'h7);
    wr(12'hb00, 32'hffff_fffe);
    repeat (4) @(negedge clk);
    rc(12'hb80, 32'h8);
    wr(12'h320, 32'h5);
    rd(12'hb00, v);
    rc(12'hb00, v);
    // hardwired event slots, random slot and word
    repeat (6) begin
      w = $urandom;
      a = (w[31] ? 12'hb80 : 12'hb00) + 12'(3 + w[30:26] % 29);
      wr(a, w);
      rc(a, 32'h0);
    end
    // security controls: interval corners first, then random
    for (int i = 0; i < 6; i++) begin
      w = $urandom;
      w[19:16] = i == 0 ? 4'h0 : i == 1 ? 4'hf : w[19:16];
      wr(12'hbf0, w);
      repeat (2) @(negedge clk);
      v = {24'h0, filler_insert_interval, idle_unit_noise_en, hint_randomize_en,
        filler_insert_en, constant_time_en};
      `CHK("sec", {24'h0, w[19:16], w[3:0]}, v)
      rc(12'hbf0, 32'h0);
    end
    foreach (sa[i]) begin
      w = $urandom;
      wr(sa[i], w);
      `CHK("seed_load", 3'(1 << i), seed_load)
      rc(sa[i], 32'h0);
      v = i == 0 ? seed0 : i == 1 ? seed1 : seed2;
      `CHK("seed", w, v)
    end
    // second reset in mid-run: written state must fall back to reset values
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    rc(12'h7b0, 32'h4000_0003);
    rc(12'h320, 32'h5);
    rc(12'h7b2, 32'h0);
    rc(12'hb80, 32'h0);
    wr(12'hf12, 32'hffff_ffff);
    rc(12'hf11, {BANKS, LAST_BYTE});
    rc(12'hf12, ARCH);
    rc(12'h123, 32'h0);
    finish_test();
  end
endmodule : dcs_regs_tb
